// ==== src/prsrc_pkg.sv ====
// prsrc_pkg: constants, states and pin bundles of the reset, strap and
// rmii clocking block.
// assumes a 200 MHz system clock.
package prsrc_pkg;

	// system clock
	localparam int CLK_PERIOD_PS = 5000;

	// output tri-state after hardware reset assertion, longest time
	localparam int T_OTAA_MAX_NS = 50;
	localparam int OTAA_MAX_CYC = (T_OTAA_MAX_NS * 1000) / CLK_PERIOD_PS;

	// output drive after hardware reset release, least and longest time
	localparam int T_ODAD_MIN_NS = 2;
	localparam int ODAD_MIN_RAW = (T_ODAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int ODAD_MIN_CYC = (ODAD_MIN_RAW < 1) ? 1 : ODAD_MIN_RAW;
	localparam int T_ODAD_MAX_NS = 800;
	localparam int ODAD_MAX_CYC = (T_ODAD_MAX_NS * 1000) / CLK_PERIOD_PS;

	// chosen wait from release to drive, inside the window above
	localparam int T_DRIVE_WAIT_NS = 400;
	localparam int DRIVE_WAIT_CYC = (T_DRIVE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int DRIVE_CNT_W = 8;

	// 50 MHz reference clock: period and high time in system cycles
	localparam int T_REF_PERIOD_NS = 20;
	localparam int REF_PERIOD_CYC = (T_REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int REF_HIGH_CYC = REF_PERIOD_CYC / 2;
	localparam int REF_CNT_W = 3;

	// clock-mode strap encodings and the value held before first capture
	localparam logic MODE_REF_OUT = 1'b0;
	localparam logic MODE_REF_IN = 1'b1;
	localparam logic STRAP_RST = MODE_REF_IN;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_WAIT = 2'b01,
		ST_DRIVE = 2'b10
	} prsrc_state_t;

	// receive pins towards the mac
	typedef struct packed {
		logic crs_dv;
		logic rx_er;
		logic [1:0] rxd;
	} prsrc_rx_pins_t;

	// transmit pins from the mac
	typedef struct packed {
		logic tx_en;
		logic [1:0] txd;
	} prsrc_tx_pins_t;

	// receive di-bit offered by the internal receive path
	typedef struct packed {
		logic valid;
		logic er;
		logic [1:0] dibit;
	} prsrc_rx_word_t;

endpackage : prsrc_pkg

// ==== src/prsrc_refclk.sv ====
// prsrc_refclk: rmii reference clock generation and rising-edge tick.
// assumes crystal and reference inputs synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module prsrc_refclk
	import prsrc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// control
	input wire logic mode_i,
	input wire logic drive_i,
	// clock pins
	input wire logic crystal_input_i,
	input wire logic ref_clock_input_i,
	output logic ref_clock_output_o,
	output logic ref_clock_output_oe_o,
	// rising edge of the reference clock
	output logic tick_o
);

	logic xtal_q;
	logic refin_q;
	logic ref_q;
	logic [REF_CNT_W-1:0] hi_cnt_q;
	logic xedge;

	// each crystal edge starts one 50 MHz period
	assign xedge = xtal_q ^ crystal_input_i;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xtal_q <= 1'b0;
			refin_q <= 1'b0;
		end else begin
			xtal_q <= crystal_input_i;
			refin_q <= ref_clock_input_i;
		end
	end

	// doubled crystal rate as the output reference clock
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_q <= 1'b0;
			hi_cnt_q <= '0;
		end else if (mode_i != MODE_REF_OUT) begin
			ref_q <= 1'b0;
			hi_cnt_q <= '0;
		end else if (xedge) begin
			ref_q <= 1'b1;
			hi_cnt_q <= REF_CNT_W'(REF_HIGH_CYC - 1);
		end else if (hi_cnt_q != '0) begin
			hi_cnt_q <= hi_cnt_q - 1'b1;
		end else begin
			ref_q <= 1'b0;
		end
	end

	always_comb begin
		if (mode_i == MODE_REF_OUT) begin
			tick_o = xedge;
		end else begin
			tick_o = ref_clock_input_i & ~refin_q;
		end
	end

	assign ref_clock_output_o = ref_q;
	assign ref_clock_output_oe_o = drive_i & (mode_i == MODE_REF_OUT);

	sequence s_ref_high;
		ref_q [*2];
	endsequence

	a_ref_shape: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(mode_i == MODE_REF_OUT) && $stable(mode_i) && xedge |=> s_ref_high)
		else $error("reference clock high time wrong");

endmodule : prsrc_refclk

`default_nettype wire

// ==== src/prsrc_top.sv ====
// prsrc_top: hardware reset acceptance, strap capture, output release and
// rmii receive and transmit timing of the transceiver.
// assumes all pins sampled as synchronous inputs of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module prsrc_top
	import prsrc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// hardware reset and strap pins
	input wire logic hw_reset_in_n_i,
	input wire logic clock_mode_strap_i,
	// clock pins
	input wire logic crystal_input_i,
	input wire logic ref_clock_input_i,
	output logic ref_clock_output_o,
	output logic ref_clock_output_oe_o,
	// rmii pins
	output prsrc_rx_pins_t rx_pins_o,
	output logic rmii_oe_o,
	input wire prsrc_tx_pins_t tx_pins_i,
	// internal receive path
	input wire logic carrier_i,
	input wire prsrc_rx_word_t rx_word_i,
	output logic rx_ready_o,
	// internal transmit path
	output prsrc_tx_pins_t tx_word_o,
	output logic tx_strobe_o,
	// status
	output logic clock_mode_o,
	output logic in_reset_o
);

	prsrc_state_t state_q;
	logic [DRIVE_CNT_W-1:0] wait_cnt_q;
	logic mode_q;
	logic drive;
	logic tick;
	logic [1:0] rxd_q;
	logic rx_er_q;
	logic tail_q;
	logic phase_q;
	prsrc_tx_pins_t tx_q;
	logic tx_strobe_q;
	logic [DRIVE_CNT_W-1:0] age_q;

	assign drive = (state_q == ST_DRIVE);

	// strap capture, follows the pin while reset is held and freezes on release
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= STRAP_RST;
		end else if (!hw_reset_in_n_i) begin
			mode_q <= clock_mode_strap_i;
		end
	end

	// reset, release wait and drive states
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_RESET;
			wait_cnt_q <= '0;
		end else if (!hw_reset_in_n_i) begin
			state_q <= ST_RESET;
			wait_cnt_q <= '0;
		end else begin
			case (state_q)
				ST_RESET: begin
					state_q <= ST_WAIT;
					wait_cnt_q <= '0;
				end
				ST_WAIT: begin
					if (wait_cnt_q == DRIVE_CNT_W'(DRIVE_WAIT_CYC - 2)) begin
						state_q <= ST_DRIVE;
					end
					wait_cnt_q <= wait_cnt_q + 1'b1;
				end
				ST_DRIVE: begin
					state_q <= ST_DRIVE;
				end
				default: begin
					state_q <= ST_RESET;
				end
			endcase
		end
	end

	prsrc_refclk u_refclk (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.mode_i(mode_q),
		.drive_i(drive),
		.crystal_input_i(crystal_input_i),
		.ref_clock_input_i(ref_clock_input_i),
		.ref_clock_output_o(ref_clock_output_o),
		.ref_clock_output_oe_o(ref_clock_output_oe_o),
		.tick_o(tick)
	);

	// one di-bit is taken per reference rising edge while driving
	assign rx_ready_o = tick & drive;

	// receive launch on the reference rising edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxd_q <= 2'h0;
			rx_er_q <= 1'b0;
			tail_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (!drive || !hw_reset_in_n_i) begin
			rxd_q <= 2'h0;
			rx_er_q <= 1'b0;
			tail_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (tick) begin
			rxd_q <= rx_word_i.valid ? rx_word_i.dibit : 2'h0;
			rx_er_q <= rx_word_i.valid & rx_word_i.er;
			tail_q <= rx_word_i.valid & ~carrier_i & phase_q;
			if (rx_word_i.valid) begin
				phase_q <= ~phase_q;
			end else begin
				phase_q <= 1'b0;
			end
		end
	end

	// carrier raises crs_dv without waiting for an edge
	always_comb begin
		rx_pins_o.crs_dv = drive & (carrier_i | tail_q);
		rx_pins_o.rx_er = rx_er_q;
		rx_pins_o.rxd = rxd_q;
	end

	assign rmii_oe_o = drive;

	// transmit sampling on the reference rising edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_q <= '0;
			tx_strobe_q <= 1'b0;
		end else if (tick && drive) begin
			tx_q <= tx_pins_i;
			tx_strobe_q <= 1'b1;
		end else begin
			tx_strobe_q <= 1'b0;
		end
	end

	assign tx_word_o = tx_q;
	assign tx_strobe_o = tx_strobe_q;
	assign clock_mode_o = mode_q;
	assign in_reset_o = (state_q == ST_RESET);

	// cycles since release, for the drive bound check
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			age_q <= '0;
		end else if (!hw_reset_in_n_i) begin
			age_q <= '0;
		end else if (age_q != '1) begin
			age_q <= age_q + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_tail_second;
		tick && drive && rx_word_i.valid && !carrier_i && phase_q;
	endsequence

	sequence s_tail_first;
		tick && drive && rx_word_i.valid && !carrier_i && !phase_q;
	endsequence

	a_tristate_reset: assert property (
		!hw_reset_in_n_i |=> !rmii_oe_o && !ref_clock_output_oe_o)
		else $error("outputs not released after reset assertion");

	a_reset_anytime: assert property (
		rmii_oe_o && !hw_reset_in_n_i |=> in_reset_o && !rx_pins_o.crs_dv)
		else $error("reset during operation not accepted");

	a_hold_low: assert property (
		!hw_reset_in_n_i [*2] |-> in_reset_o && !rmii_oe_o)
		else $error("low reset level did not hold the device");

	a_drive_bound: assert property (
		hw_reset_in_n_i && (age_q >= DRIVE_CNT_W'(ODAD_MAX_CYC)) |-> rmii_oe_o)
		else $error("outputs not driven within release bound");

	a_drive_early: assert property (
		$rose(hw_reset_in_n_i) |-> !rmii_oe_o ##1 !rmii_oe_o)
		else $error("outputs driven too soon after release");

	a_strap_capture: assert property (
		!hw_reset_in_n_i |=> clock_mode_o == $past(clock_mode_strap_i))
		else $error("strap not captured during reset");

	a_strap_hold: assert property (
		hw_reset_in_n_i |=> $stable(clock_mode_o))
		else $error("strap value changed outside reset");

	a_launch_edge: assert property (
		drive && $past(drive) && !$past(tick) |-> $stable(rx_pins_o.rxd))
		else $error("receive di-bit changed off the reference edge");

	a_tx_sample: assert property (
		tick && drive |=> tx_strobe_o && tx_word_o == $past(tx_pins_i))
		else $error("transmit pins not sampled on reference edge");

	a_crs_async: assert property (
		drive && carrier_i |-> rx_pins_o.crs_dv)
		else $error("crs_dv not raised with carrier");

	a_crs_second: assert property (
		s_tail_second ##1 drive && !carrier_i |-> rx_pins_o.crs_dv)
		else $error("crs_dv low on second di-bit after carrier");

	a_crs_first: assert property (
		s_tail_first ##1 drive && !carrier_i |-> !rx_pins_o.crs_dv)
		else $error("crs_dv high on first di-bit after carrier");

endmodule : prsrc_top

`default_nettype wire

// ==== test/prsrc_mac_model.sv ====
// prsrc_mac_model: far-side clock sources, crystal and 50 MHz reference.
// assumes the bench system clock at 200 MHz.
`timescale 1ns/1ps
`default_nettype none

module prsrc_mac_model (
	// system clock
	input wire logic clk_sys_i,
	// clock pins towards the device
	output logic crystal_o,
	output logic ref_clock_o
);
	logic [1:0] cnt_q = 2'h0;
	logic xtal_q = 1'b0;

	// changes just after each edge, so the device sees settled levels
	always_ff @(posedge clk_sys_i) begin
		cnt_q <= cnt_q + 2'h1;
		// 25 MHz crystal: one edge every 4 system cycles
		if (cnt_q == 2'h3) begin
			xtal_q <= ~xtal_q;
		end
	end

	assign crystal_o = xtal_q;
	// free-running reference: 20 ns period, 2 high and 2 low
	assign ref_clock_o = cnt_q[1];
endmodule : prsrc_mac_model

`default_nettype wire

// ==== test/tb_prsrc_top.sv ====
// tb_prsrc_top: self-checking bench of the reset, strap and rmii block.
// assumes prsrc_mac_model supplies crystal and reference clocks.
`timescale 1ns/1ps
`default_nettype none

module tb_prsrc_top
	import prsrc_pkg::*;
();
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	// supplies settle before time zero, hardware reset low from power-up
	logic hw_n = 1'b0;
	logic strap = 1'b1;
	logic carrier = 1'b0;
	prsrc_tx_pins_t tx_pins = 3'h0;
	prsrc_rx_word_t rx_word = 4'h0;
	logic crystal, ref_in, ref_o, ref_oe, rmii_oe, rx_rdy;
	logic tx_stb, mode_o, in_rst;
	prsrc_rx_pins_t rx_pins;
	prsrc_tx_pins_t tx_word;
	int n_fail = 0;
	int num_checks = 0;
	// hardware reset hold, 100 us in 5 ns cycles
	localparam int HW_HOLD_CYC = 20000;

	always #2.5 clk_sys_i = ~clk_sys_i;

	prsrc_mac_model mac_u (.clk_sys_i(clk_sys_i), .crystal_o(crystal),
		.ref_clock_o(ref_in));

	prsrc_top dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.hw_reset_in_n_i(hw_n), .clock_mode_strap_i(strap),
		.crystal_input_i(crystal), .ref_clock_input_i(ref_in),
		.ref_clock_output_o(ref_o), .ref_clock_output_oe_o(ref_oe),
		.rx_pins_o(rx_pins), .rmii_oe_o(rmii_oe), .tx_pins_i(tx_pins),
		.carrier_i(carrier), .rx_word_i(rx_word), .rx_ready_o(rx_rdy),
		.tx_word_o(tx_word), .tx_strobe_o(tx_stb),
		.clock_mode_o(mode_o), .in_reset_o(in_rst));

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// waits for the next reference tick while driving
	task wait_rdy;
		int i;
		i = 0;
		while (rx_rdy !== 1'b1 && i < 20) begin
			@(negedge clk_sys_i);
			i++;
		end
		chk(rx_rdy, 8'h1);
	endtask : wait_rdy

	// hardware reset in mid-run with carrier up, strap moving
	task hw_reset(input logic mode);
		int n;
		@(negedge clk_sys_i);
		hw_n = 1'b0;
		carrier = 1'b1;
		strap = ~mode;
		@(negedge clk_sys_i);
		chk({in_rst, rmii_oe, ref_oe, rx_pins}, 8'h40);
		carrier = 1'b0;
		strap = mode;
		repeat (HW_HOLD_CYC - 1) @(negedge clk_sys_i);
		hw_n = 1'b1;
		n = 0;
		while (rmii_oe !== 1'b1 && n < ODAD_MAX_CYC) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk(n >= ODAD_MIN_CYC && n < ODAD_MAX_CYC, 8'h1);
		chk({mode_o, ref_oe, in_rst}, {mode, ~mode, 1'b0});
		strap = ~mode;
		repeat (4) @(negedge clk_sys_i);
		chk(mode_o, mode);
		strap = mode;
	endtask : hw_reset

	// reference output: high time and period in system cycles
	task ref_chk(input logic mode);
		int hi, rs;
		logic prev;
		hi = 0;
		rs = 0;
		prev = ref_o;
		repeat (40) begin
			@(negedge clk_sys_i);
			hi += (ref_o === 1'b1);
			rs += (ref_o === 1'b1 && prev === 1'b0);
			prev = ref_o;
		end
		chk(8'(hi), mode ? 8'h0 : 8'd20);
		chk(8'(rs), mode ? 8'h0 : 8'd10);
	endtask : ref_chk

	task t_tx(input prsrc_tx_pins_t v);
		@(negedge clk_sys_i);
		tx_pins = v;
		wait_rdy();
		@(negedge clk_sys_i);
		chk({tx_stb, tx_word}, {1'b1, v});
		tx_pins = ~v;
		@(negedge clk_sys_i);
		chk(tx_stb, 8'h0);
	endtask : t_tx

	task t_rx(input prsrc_rx_word_t w, input logic cdv);
		@(negedge clk_sys_i);
		rx_word = w;
		wait_rdy();
		@(negedge clk_sys_i);
		if (w.valid) begin
			chk(rx_pins, {cdv, w.er, w.dibit});
		end else begin
			chk(rx_pins.crs_dv, cdv);
		end
		rx_word = ~w;
	endtask : t_rx

	// carrier raises crs_dv at once, then the di-bit tail toggles it
	task t_crs;
		@(negedge clk_sys_i);
		carrier = 1'b1;
		#1;
		chk(rx_pins.crs_dv, 8'h1);
		t_rx(4'h9, 1'b1);
		carrier = 1'b0;
		t_rx(4'h0, 1'b0);
		t_rx(4'h9, 1'b0);
		t_rx(4'ha, 1'b1);
		t_rx(4'hf, 1'b0);
		t_rx(4'h8, 1'b1);
		t_rx(4'h0, 1'b0);
	endtask : t_crs

	initial begin
		repeat (10) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		for (int m = 0; m < 2; m++) begin
			hw_reset(m[0]);
			ref_chk(m[0]);
			t_tx(3'h5);
			t_tx(3'h2);
			t_crs();
		end
		end_of_test();
	end

	// two long hardware resets plus short scenarios, with margin
	initial begin
		repeat (3 * HW_HOLD_CYC) @(negedge clk_sys_i);
		n_fail++;
		end_of_test();
	end
endmodule : tb_prsrc_top

`default_nettype wire
